// file: cond_add_pkg.sv
// Shared constants, flag layout and condition encodings for the evaluator
package cond_add_pkg;

    localparam int DATA_W   = 8;
    localparam int NIBBLE_W = 4;

    // Flag positions inside the flags register
    localparam int FLAG_CARRY_POS    = 7;
    localparam int FLAG_ZERO_POS     = 6;
    localparam int FLAG_SIGN_POS     = 5;
    localparam int FLAG_OVERFLOW_POS = 4;
    localparam int FLAG_DECIMAL_POS  = 3;
    localparam int FLAG_HALF_POS     = 2;
    localparam int FLAG_FAST_POS     = 1;
    localparam int FLAG_BANK_POS     = 0;

    typedef struct packed {
        logic carry;
        logic zero;
        logic sign;
        logic overflow;
        logic decimal;
        logic half;
        logic fast_irq;
        logic bank;
    } flags_s;

    typedef struct packed {
        logic unknown_op;
        logic add_done;
        logic not_taken;
        logic taken;
    } status_s;

    localparam logic [7:0] FLAGS_RESET  = 8'h00;
    localparam logic [7:0] DST_RESET    = 8'h00;
    localparam logic [7:0] SRC_RESET    = 8'h00;
    localparam logic [3:0] STATUS_RESET = 4'h0;

    // Register byte offsets on the bus
    localparam logic [7:0] REG_FLAGS_OFS  = 8'h00;
    localparam logic [7:0] REG_DST_OFS    = 8'h04;
    localparam logic [7:0] REG_SRC_OFS    = 8'h08;
    localparam logic [7:0] REG_CMD_OFS    = 8'h0c;
    localparam logic [7:0] REG_STATUS_OFS = 8'h10;

    // Condition field encodings; aliases share one code
    localparam logic [3:0] cond_never        = 4'h0;
    localparam logic [3:0] cond_always       = 4'h8;
    localparam logic [3:0] cond_carry        = 4'h7;
    localparam logic [3:0] cond_no_carry     = 4'hf;
    localparam logic [3:0] cond_zero         = 4'h6;
    localparam logic [3:0] cond_not_zero     = 4'he;
    localparam logic [3:0] cond_equal        = 4'h6;
    localparam logic [3:0] cond_not_equal    = 4'he;
    localparam logic [3:0] cond_plus         = 4'hd;
    localparam logic [3:0] cond_minus        = 4'h5;
    localparam logic [3:0] cond_overflow     = 4'h4;
    localparam logic [3:0] cond_no_overflow  = 4'hc;
    localparam logic [3:0] cond_signed_ge    = 4'h9;
    localparam logic [3:0] cond_signed_lt    = 4'h1;
    localparam logic [3:0] cond_signed_gt    = 4'ha;
    localparam logic [3:0] cond_signed_le    = 4'h2;
    localparam logic [3:0] cond_unsigned_ge  = 4'hf;
    localparam logic [3:0] cond_unsigned_lt  = 4'h7;
    localparam logic [3:0] cond_unsigned_gt  = 4'hb;
    localparam logic [3:0] cond_unsigned_le  = 4'h3;

    // Add-with-carry opcodes, all five operand forms
    localparam logic [7:0] OPC_ADD_CARRY_RR  = 8'h12;
    localparam logic [7:0] OPC_ADD_CARRY_RI  = 8'h13;
    localparam logic [7:0] OPC_ADD_CARRY_GG  = 8'h14;
    localparam logic [7:0] OPC_ADD_CARRY_GI  = 8'h15;
    localparam logic [7:0] OPC_ADD_CARRY_IMM = 8'h16;

    // Low nibble of conditional jump opcodes; high nibble is the condition
    localparam logic [3:0] JUMP_DIRECT_NIB   = 4'hd;
    localparam logic [3:0] JUMP_RELATIVE_NIB = 4'hb;

endpackage

// file: cond_evaluator.sv
// Condition field test against carry, zero, sign and overflow
`timescale 1ns/1ns
module cond_evaluator
    import cond_add_pkg::*;
(
    input  wire logic [3:0] cond,      // Condition field
    input  wire logic       carry,     // Carry flag
    input  wire logic       zero,      // Zero flag
    input  wire logic       sign,      // Sign flag
    input  wire logic       overflow,  // Overflow flag
    output logic            taken      // Condition true
);
    logic signed_less;

    always_comb begin
        signed_less = sign ^ overflow;
        case (cond)
            cond_never:       taken = 1'b0;
            cond_always:      taken = 1'b1;
            cond_equal:       taken = zero;
            cond_not_equal:   taken = ~zero;
            cond_plus:        taken = ~sign;
            cond_minus:       taken = sign;
            cond_overflow:    taken = overflow;
            cond_no_overflow: taken = ~overflow;
            cond_signed_ge:   taken = ~signed_less;
            cond_signed_lt:   taken = signed_less;
            cond_signed_gt:   taken = ~(zero | signed_less);
            cond_signed_le:   taken = zero | signed_less;
            cond_no_carry:    taken = ~carry;
            cond_carry:       taken = carry;
            cond_unsigned_gt: taken = ~carry & ~zero;
            cond_unsigned_le: taken = carry | zero;
            default:          taken = 1'b0;
        endcase
    end
endmodule

// file: add_carry_unit.sv
// Two's-complement adder with carry in and arithmetic flag outputs
`timescale 1ns/1ns
module add_carry_unit
    import cond_add_pkg::*;
#(
    parameter int WIDTH = DATA_W
)(
    input  wire logic [WIDTH-1:0] dst,        // Destination operand
    input  wire logic [WIDTH-1:0] src,        // Source operand
    input  wire logic             carry_in,   // Current carry flag
    output logic      [WIDTH-1:0] sum,        // Result
    output logic                  carry_out,  // Carry out of top bit
    output logic                  half_carry, // Carry out of low nibble
    output logic                  overflow,   // Signed overflow
    output logic                  zero,       // Result is zero
    output logic                  sign        // Result negative
);
    logic [WIDTH:0]    full;
    logic [NIBBLE_W:0] low;

    always_comb begin
        full       = {1'b0, dst} + {1'b0, src} + {{WIDTH{1'b0}}, carry_in};
        low        = {1'b0, dst[NIBBLE_W-1:0]} + {1'b0, src[NIBBLE_W-1:0]}
                   + {{NIBBLE_W{1'b0}}, carry_in};
        sum        = full[WIDTH-1:0];
        carry_out  = full[WIDTH];
        half_carry = low[NIBBLE_W];
        overflow   = (dst[WIDTH-1] == src[WIDTH-1]) && (sum[WIDTH-1] != dst[WIDTH-1]);
        zero       = (sum == '0);
        sign       = sum[WIDTH-1];
    end
endmodule

// file: cond_code_eval_add_carry.sv
// Condition evaluation and add-with-carry execution behind an AHB-Lite slave
//
// Notes on behaviour
// - Jump opcodes carry a 4-bit condition; jump taken only when true.
// - Code 0000 never jumps; code 1000 always jumps.
// - 0110 true when zero set; 1110 true when zero clear.
// - 1101 sign clear, 0101 sign set, 0100 overflow set, 1100 clear.
// - 1001 true when sign xor overflow is 0; 0001 when 1.
// - 1010 true when zero or (sign xor overflow) is 0; 0010 when 1.
// - 1111 true when carry clear; 0111 true when carry set.
// - 1011 true only when carry and zero both clear.
// - 0011 true when carry or zero is set.
// - Aliased condition names share one code and decode identically.
// - Add-with-carry writes dst+src+carry to dst; source unchanged.
// - Carry set on carry out of the top result bit.
// - Zero set when result is zero; sign set when negative.
// - Overflow set when operand signs agree and result sign differs.
// - Decimal flag cleared; half carry from the low nibble.
// - Carry, zero, sign, overflow sit in flags bits 7 to 4.
`timescale 1ns/1ns
module cond_code_eval_add_carry (
    input  wire logic                    clk,          // Clock, 25 MHz
    input  wire logic                    rst,          // Async reset, high
    input  wire logic                    hsel,         // Slave select
    input  wire logic [31:0]             haddr,        // Byte address
    input  wire logic [1:0]              htrans,       // Transfer type
    input  wire logic                    hwrite,       // Write when high
    input  wire logic [2:0]              hsize,        // Word only
    input  wire logic [31:0]             hwdata,       // Write data
    input  wire logic                    hready,       // Bus ready
    output logic      [31:0]             hrdata,       // Read data
    output logic                         hreadyout,    // Slave ready
    output logic                         hresp,        // Always OKAY
    output logic                         jump_taken,   // Jump pulse
    output logic                         next_seq,     // Fall-through pulse
    output cond_add_pkg::flags_s         flags_out     // Flags register
);
    import cond_add_pkg::*;

    typedef enum logic [0:0] {
        bus_idle = 1'b0,
        bus_read = 1'b1
    } bus_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave state

    bus_state_e  state_q,     state_d;
    logic        wr_pend_q,   wr_pend_d;
    logic [7:0]  wr_addr_q,   wr_addr_d;
    logic [7:0]  rd_addr_q,   rd_addr_d;
    logic [31:0] hrdata_q,    hrdata_d;
    logic        hreadyout_q, hreadyout_d;
    logic        accept;

    ////////////////////////////////////////////////////////////////////////////
    // Block state

    flags_s      flags_q,     flags_d;
    logic [7:0]  dst_q,       dst_d;
    logic [7:0]  src_q,       src_d;
    status_s     status_q,    status_d;
    logic        taken_q,     taken_d;
    logic        next_q,      next_d;

    logic [7:0]  opcode;
    logic [3:0]  exec_cond;
    logic        cmd_wr;
    logic        is_jump;
    logic        is_add;
    logic        exec_jump;
    logic        exec_add;
    logic        cond_true;
    logic [7:0]  add_sum;
    logic        add_carry;
    logic        add_half;
    logic        add_ovf;
    logic        add_zero;
    logic        add_sign;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode

    always_comb begin
        cmd_wr    = wr_pend_q && (wr_addr_q == REG_CMD_OFS);
        opcode    = hwdata[7:0];
        exec_cond = opcode[7:4];
        is_jump   = (opcode[3:0] == JUMP_DIRECT_NIB) || (opcode[3:0] == JUMP_RELATIVE_NIB);
        // every operand form decodes to one path
        is_add    = (opcode == OPC_ADD_CARRY_RR) || (opcode == OPC_ADD_CARRY_RI)
                 || (opcode == OPC_ADD_CARRY_GG) || (opcode == OPC_ADD_CARRY_GI)
                 || (opcode == OPC_ADD_CARRY_IMM);
        exec_jump = cmd_wr && is_jump;
        exec_add  = cmd_wr && is_add;
    end

    // tested flags from bits 7 to 4
    cond_evaluator u_eval (
        .cond     (exec_cond),
        .carry    (flags_q.carry),
        .zero     (flags_q.zero),
        .sign     (flags_q.sign),
        .overflow (flags_q.overflow),
        .taken    (cond_true)
    );

    add_carry_unit #(
        .WIDTH (DATA_W)
    ) u_add (
        .dst        (dst_q),
        .src        (src_q),
        .carry_in   (flags_q.carry),
        .sum        (add_sum),
        .carry_out  (add_carry),
        .half_carry (add_half),
        .overflow   (add_ovf),
        .zero       (add_zero),
        .sign       (add_sign)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave next state

    always_comb begin
        accept      = hsel && htrans[1] && hready;
        state_d     = state_q;
        wr_pend_d   = 1'b0;
        wr_addr_d   = wr_addr_q;
        rd_addr_d   = rd_addr_q;
        hrdata_d    = hrdata_q;
        hreadyout_d = hreadyout_q;
        case (state_q)
            bus_idle: begin
                if (accept && hwrite) begin
                    wr_pend_d = 1'b1;
                    wr_addr_d = haddr[7:0];
                end else if (accept) begin
                    // One wait state so a write just before is seen
                    rd_addr_d   = haddr[7:0];
                    state_d     = bus_read;
                    hreadyout_d = 1'b0;
                end
            end
            bus_read: begin
                case (rd_addr_q)
                    REG_FLAGS_OFS:  hrdata_d = {24'h000000, flags_q};
                    REG_DST_OFS:    hrdata_d = {24'h000000, dst_q};
                    REG_SRC_OFS:    hrdata_d = {24'h000000, src_q};
                    REG_STATUS_OFS: hrdata_d = {28'h0000000, status_q};
                    default:        hrdata_d = 32'h00000000;
                endcase
                state_d     = bus_idle;
                hreadyout_d = 1'b1;
            end
            default: begin
                state_d     = bus_idle;
                hreadyout_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= bus_idle;
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 8'h00;
            rd_addr_q   <= 8'h00;
            hrdata_q    <= 32'h00000000;
            hreadyout_q <= 1'b1;
        end else begin
            state_q     <= state_d;
            wr_pend_q   <= wr_pend_d;
            wr_addr_q   <= wr_addr_d;
            rd_addr_q   <= rd_addr_d;
            hrdata_q    <= hrdata_d;
            hreadyout_q <= hreadyout_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and execution

    always_comb begin
        flags_d  = flags_q;
        dst_d    = dst_q;
        src_d    = src_q;
        status_d = status_q;
        taken_d  = 1'b0;
        next_d   = 1'b0;
        if (wr_pend_q) begin
            case (wr_addr_q)
                REG_FLAGS_OFS: flags_d = flags_s'(hwdata[7:0]);
                REG_DST_OFS:   dst_d   = hwdata[7:0];
                REG_SRC_OFS:   src_d   = hwdata[7:0];
                REG_CMD_OFS: begin
                    status_d = status_s'(STATUS_RESET);
                    if (is_add) begin
                        dst_d            = add_sum;
                        flags_d.carry    = add_carry;
                        flags_d.zero     = add_zero;
                        flags_d.sign     = add_sign;
                        flags_d.overflow = add_ovf;
                        flags_d.decimal  = 1'b0;
                        flags_d.half     = add_half;
                        status_d.add_done = 1'b1;
                    end else if (is_jump) begin
                        // jump only on a true condition
                        taken_d = cond_true;
                        next_d  = ~cond_true;
                        status_d.taken     = cond_true;
                        status_d.not_taken = ~cond_true;
                    end else begin
                        status_d.unknown_op = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_q  <= flags_s'(FLAGS_RESET);
            dst_q    <= DST_RESET;
            src_q    <= SRC_RESET;
            status_q <= status_s'(STATUS_RESET);
            taken_q  <= 1'b0;
            next_q   <= 1'b0;
        end else begin
            flags_q  <= flags_d;
            dst_q    <= dst_d;
            src_q    <= src_d;
            status_q <= status_d;
            taken_q  <= taken_d;
            next_q   <= next_d;
        end
    end

    assign hrdata     = hrdata_q;
    assign hreadyout  = hreadyout_q;
    assign hresp      = 1'b0;
    assign jump_taken = taken_q;
    assign next_seq   = next_q;
    assign flags_out  = flags_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence jump_with(logic [3:0] code);
        exec_jump && (exec_cond == code);
    endsequence

    sequence add_issued;
        exec_add;
    endsequence

    never_jump_a: assert property (jump_with(cond_never) |=> !jump_taken && next_seq)
        else $error("never condition took the jump");
    always_jump_a: assert property (jump_with(cond_always) |=> jump_taken && !next_seq)
        else $error("always condition did not jump");
    zero_test_a: assert property (jump_with(cond_equal) |=> jump_taken == $past(flags_q.zero))
        else $error("zero condition wrong");
    sign_test_a: assert property (jump_with(cond_plus) |=> jump_taken == !$past(flags_q.sign))
        else $error("plus condition wrong");
    signed_less_a: assert property (jump_with(cond_signed_lt)
                     |=> jump_taken == ($past(flags_q.sign) ^ $past(flags_q.overflow)))
        else $error("signed less condition wrong");
    signed_greater_a: assert property (jump_with(cond_signed_gt) |=> jump_taken ==
                     !($past(flags_q.zero) | ($past(flags_q.sign) ^ $past(flags_q.overflow))))
        else $error("signed greater condition wrong");
    unsigned_order_a: assert property (jump_with(cond_unsigned_gt)
                     |=> jump_taken == (!$past(flags_q.carry) && !$past(flags_q.zero)))
        else $error("unsigned greater condition wrong");
    jump_outcome_a: assert property (exec_jump |=> (jump_taken ^ next_seq)
                     ##1 (!jump_taken || $past(exec_jump)))
        else $error("jump outcome not a single exclusive pulse");
    flags_kept_a: assert property (exec_jump |=> $stable(flags_q))
        else $error("evaluation changed flags");
    add_result_a: assert property (add_issued |=> dst_q == 8'($past(dst_q) + $past(src_q)
                     + {7'h00, $past(flags_q.carry)}) && $stable(src_q))
        else $error("add with carry result wrong");
    add_flags_a: assert property (add_issued |=> !flags_q.decimal && flags_q.zero == (dst_q == 8'h00)
                     && flags_q.sign == dst_q[7])
        else $error("add with carry flags wrong");
    add_overflow_a: assert property (add_issued |=> flags_q.overflow == (($past(dst_q[7])
                     == $past(src_q[7])) && (dst_q[7] != $past(dst_q[7]))))
        else $error("add with carry overflow wrong");
    minus_test_a: assert property (jump_with(cond_minus) |=> jump_taken == $past(flags_q.sign))
        else $error("minus condition wrong");
    carry_test_a: assert property (jump_with(cond_carry) |=> jump_taken == $past(flags_q.carry))
        else $error("carry condition wrong");
    unsigned_le_a: assert property (jump_with(cond_unsigned_le)
                     |=> jump_taken == ($past(flags_q.carry) | $past(flags_q.zero)))
        else $error("unsigned less or equal condition wrong");
    // One wait state per read data phase
    read_wait_a: assert property ($fell(hreadyout) |=> hreadyout)
        else $error("read wait state not one cycle");
endmodule

// file: tb_cond_add.sv
// Self-checking bench for condition evaluation and add-with-carry over AHB-Lite
`timescale 1ns/1ns
module testbench;
    import cond_add_pkg::*;

    logic        clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        jump_taken;
    logic        next_seq;
    flags_s      flags_out;
    int          n_fail;
    int          n_tests;

    cond_code_eval_add_carry dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .jump_taken(jump_taken), .next_seq(next_seq), .flags_out(flags_out)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for hready; data sampled at the falling edge before the accepting edge
    task automatic wait_ready(output logic [31:0] rd);
        int n = 0;
        @(negedge clk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (n >= 50) begin
            n_fail++;
            give_verdict();
        end
        rd = hrdata;
        @(posedge clk);
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] dummy;
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        wait_ready(dummy);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_ready(dummy);
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        wait_ready(rd);
        htrans <= 2'b00;
        // Read data phase opens with one wait state
        @(negedge clk);
        check({31'h0, hreadyout}, 32'h0);
        wait_ready(rd);
    endtask

    function automatic logic exp_cond(input logic [3:0] code, input logic [3:0] f);
        logic c = f[3];
        logic z = f[2];
        logic s = f[1];
        logic v = f[0];
        case (code)
            4'h0: return 1'b0;
            4'h8: return 1'b1;
            4'h7: return c;
            4'hf: return !c;
            4'h6: return z;
            4'he: return !z;
            4'hd: return !s;
            4'h5: return s;
            4'h4: return v;
            4'hc: return !v;
            4'h9: return !(s ^ v);
            4'h1: return s ^ v;
            4'ha: return !(z | (s ^ v));
            4'h2: return z | (s ^ v);
            4'hb: return !c && !z;
            default: return c | z;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        logic [31:0] r;
        check({31'h0, hreadyout}, 32'h1);
        check({24'h0, flags_out}, 32'h0);
        bus_read(REG_FLAGS_OFS, r);
        check(r, 32'h0);
        bus_read(REG_DST_OFS, r);
        check(r, 32'h0);
        bus_read(REG_STATUS_OFS, r);
        check(r, 32'h0);
    endtask

    // Every code against every flag pattern; odd codes use the direct jump form, even codes the relative
    task automatic test_conditions();
        logic [31:0] r;
        logic        e;
        for (int f = 0; f < 16; f++) begin
            bus_write(REG_FLAGS_OFS, {f[3:0], 4'h5});
            for (int code = 0; code < 16; code++) begin
                bus_write(REG_CMD_OFS,
                          {code[3:0], code[0] ? JUMP_DIRECT_NIB : JUMP_RELATIVE_NIB});
                e = exp_cond(code[3:0], f[3:0]);
                @(negedge clk);
                check({30'h0, jump_taken, next_seq}, {30'h0, e, !e});
                check({24'h0, flags_out}, {24'h0, f[3:0], 4'h5});
                @(negedge clk);
                check({30'h0, jump_taken, next_seq}, 32'h0);
                bus_read(REG_STATUS_OFS, r);
                check(r, {30'h0, !e, e});
            end
        end
    endtask

    // One case per opcode form; carries, zero, sign, overflow, half carry
    task automatic test_add_carry();
        logic [7:0]  dv [5] = '{8'h10, 8'hff, 8'h7f, 8'h80, 8'h08};
        logic [7:0]  sv [5] = '{8'h03, 8'h00, 8'h00, 8'h80, 8'h07};
        logic        cv [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        logic [8:0]  su;
        logic [4:0]  lo;
        logic [7:0]  ef;
        logic [31:0] r;
        for (int i = 0; i < 5; i++) begin
            su = {1'b0, dv[i]} + {1'b0, sv[i]} + {8'h0, cv[i]};
            lo = {1'b0, dv[i][3:0]} + {1'b0, sv[i][3:0]} + {4'h0, cv[i]};
            ef = {su[8], su[7:0] == 8'h00, su[7],
                  (dv[i][7] == sv[i][7]) && (su[7] != dv[i][7]), 1'b0, lo[4], 2'b11};
            bus_write(REG_FLAGS_OFS, {cv[i], 3'b111, 4'hb});
            bus_write(REG_DST_OFS, dv[i]);
            bus_write(REG_SRC_OFS, sv[i]);
            bus_write(REG_CMD_OFS, OPC_ADD_CARRY_RR + 8'(i));
            @(negedge clk);
            check({24'h0, flags_out}, {24'h0, ef});
            check({30'h0, jump_taken, next_seq}, 32'h0);
            bus_read(REG_DST_OFS, r);
            check(r, {24'h0, su[7:0]});
            bus_read(REG_SRC_OFS, r);
            check(r, {24'h0, sv[i]});
            bus_read(REG_STATUS_OFS, r);
            check(r, 32'h4);
        end
    endtask

    // Non-jump, non-add opcode and unmapped accesses
    task automatic test_other();
        logic [31:0] r;
        bus_write(REG_CMD_OFS, 8'h00);
        @(negedge clk);
        check({30'h0, jump_taken, next_seq}, 32'h0);
        bus_read(REG_STATUS_OFS, r);
        check(r, 32'h8);
        bus_write(8'h20, 8'hab);
        bus_read(8'h20, r);
        check(r, 32'h0);
        bus_read(REG_CMD_OFS, r);
        check(r, 32'h0);
        check({31'h0, hresp}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst     = 1'b1;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'b00;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        n_fail  = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        test_reset();
        test_conditions();
        test_add_carry();
        test_other();
        give_verdict();
    end
endmodule
